// ===== core/rtcal_serial_port.sv
module rtcal_serial_port (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   select_pin,
  input  wire logic                   sclk_pin,
  input  wire logic                   serial_io_pin_in,
  output logic                        serial_io_pin_out,
  output logic                        serial_io_pin_oe,
  input  wire rtcal_pkg::rtcal_time_s cur_time,
  output logic                        weekly_match,
  output logic                        daily_match
);

  // ----------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------
  logic [2:0] pins_f;
  logic       sel_f, sclk_f, sio_f;
  logic       sel_q_ff, sclk_q_ff;
  logic       sel_rise, sclk_rise, sclk_fall;

  rtcal_pin_sync #(.W(3)) u_sync (
    .clk       (clk),
    .rstn      (rstn),
    .async_in  ({select_pin, sclk_pin, serial_io_pin_in}),
    .level_out (pins_f)
  );

  assign sel_f     = pins_f[2];
  assign sclk_f    = pins_f[1];
  assign sio_f     = pins_f[0];
  assign sel_rise  = sel_f & ~sel_q_ff;
  assign sclk_rise = sclk_f & ~sclk_q_ff;
  assign sclk_fall = ~sclk_f & sclk_q_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q_ff  <= 1'b0;
      sclk_q_ff <= 1'b0;
    end else begin
      sel_q_ff  <= sel_f;
      sclk_q_ff <= sclk_f;
    end
  end

  // ----------------------------------------
  // Framing state
  // ----------------------------------------
  rtcal_pkg::rtcal_phase_e phase_ff, nxt_phase;
  rtcal_pkg::rtcal_alarm_s regs_ff, nxt_regs;
  logic                    pol_ff, nxt_pol;
  logic [2:0]              bit_cnt_ff, nxt_bit_cnt;
  logic [6:0]              shift_ff, nxt_shift;
  logic [3:0]              addr_ff, nxt_addr;
  logic [3:0]              fmt_ff, nxt_fmt;
  logic [7:0]              tx_ff, nxt_tx;
  logic                    sio_out_ff, nxt_sio_out;
  logic                    sio_oe_ff, nxt_sio_oe;
  logic                    cap_edge, drv_edge, byte_done;
  logic                    in_read, wr_commit;
  logic [7:0]              rx_byte;
  logic [3:0]              addr_inc;

  // Unmapped addresses read zero; narrow fields sit low
  function automatic logic [7:0] rd_reg(input logic [3:0] a,
                                        input rtcal_pkg::rtcal_alarm_s r);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      rtcal_pkg::ADDR_WK_MIN:  d = {1'b0, r.wk_min};
      rtcal_pkg::ADDR_WK_HOUR: d = {2'b00, r.wk_hour};
      rtcal_pkg::ADDR_WK_DAYS: d = {1'b0, r.wk_days};
      rtcal_pkg::ADDR_DY_MIN:  d = {1'b0, r.dy_min};
      rtcal_pkg::ADDR_DY_HOUR: d = {2'b00, r.dy_hour};
      default:                 d = 8'h00;
    endcase
    return d;
  endfunction

  assign cap_edge  = (phase_ff != rtcal_pkg::RTCAL_IDLE) && sel_f &&
                     (pol_ff ? sclk_rise : sclk_fall);
  assign drv_edge  = (phase_ff != rtcal_pkg::RTCAL_IDLE) && sel_f &&
                     (pol_ff ? sclk_fall : sclk_rise);
  assign rx_byte   = {shift_ff, sio_f};
  assign byte_done = cap_edge && (bit_cnt_ff == rtcal_pkg::BIT_CNT_LAST);
  assign in_read   = fmt_ff[rtcal_pkg::FMT_READ_BIT];
  assign wr_commit = byte_done && (phase_ff == rtcal_pkg::RTCAL_DATA) && !in_read;
  assign addr_inc  = addr_ff + 4'h1;

  always_comb begin
    nxt_phase   = phase_ff;
    nxt_pol     = pol_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_addr    = addr_ff;
    nxt_fmt     = fmt_ff;
    nxt_tx      = tx_ff;
    nxt_sio_out = sio_out_ff;
    nxt_sio_oe  = sio_oe_ff;
    if (!sel_f) begin
      nxt_phase  = rtcal_pkg::RTCAL_IDLE;
      nxt_sio_oe = 1'b0;
    end else if (sel_rise) begin
      nxt_phase   = rtcal_pkg::RTCAL_CMD;
      nxt_bit_cnt = rtcal_pkg::BIT_CNT_RST;
      nxt_sio_oe  = 1'b0;
      nxt_pol     = sclk_f;
    end else begin
      if (cap_edge) begin
        nxt_shift   = rx_byte[6:0];
        nxt_bit_cnt = bit_cnt_ff + 3'h1;
      end
      if (byte_done && phase_ff == rtcal_pkg::RTCAL_CMD) begin
        nxt_addr  = rx_byte[7:4];
        nxt_fmt   = rx_byte[3:0];
        nxt_phase = rtcal_pkg::RTCAL_DATA;
        nxt_tx    = rd_reg(rx_byte[7:4], regs_ff);
      end else if (byte_done) begin
        if (fmt_ff[rtcal_pkg::FMT_SINGLE_BIT]) begin
          nxt_phase = rtcal_pkg::RTCAL_CMD;
        end else begin
          nxt_addr = addr_inc;
          nxt_tx   = rd_reg(addr_inc, regs_ff);
        end
      end
      if (drv_edge) begin
        if (phase_ff == rtcal_pkg::RTCAL_DATA && in_read) begin
          nxt_sio_out = tx_ff[7];
          nxt_tx      = {tx_ff[6:0], 1'b0};
          nxt_sio_oe  = 1'b1;
        end else begin
          nxt_sio_oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_ff   <= rtcal_pkg::RTCAL_IDLE;
      pol_ff     <= 1'b0;
      bit_cnt_ff <= rtcal_pkg::BIT_CNT_RST;
      shift_ff   <= 7'h00;
      addr_ff    <= rtcal_pkg::NIBBLE_RST;
      fmt_ff     <= rtcal_pkg::NIBBLE_RST;
      tx_ff      <= rtcal_pkg::BYTE_RST;
      sio_out_ff <= 1'b0;
      sio_oe_ff  <= 1'b0;
    end else begin
      phase_ff   <= nxt_phase;
      pol_ff     <= nxt_pol;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      addr_ff    <= nxt_addr;
      fmt_ff     <= nxt_fmt;
      tx_ff      <= nxt_tx;
      sio_out_ff <= nxt_sio_out;
      sio_oe_ff  <= nxt_sio_oe;
    end
  end

  // ----------------------------------------
  // Alarm registers
  // ----------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    if (wr_commit) begin
      unique case (addr_ff)
        rtcal_pkg::ADDR_WK_MIN:  nxt_regs.wk_min  = rx_byte[6:0];
        rtcal_pkg::ADDR_WK_HOUR: nxt_regs.wk_hour = rx_byte[5:0];
        rtcal_pkg::ADDR_WK_DAYS: nxt_regs.wk_days = rx_byte[6:0];
        rtcal_pkg::ADDR_DY_MIN:  nxt_regs.dy_min  = rx_byte[6:0];
        // codes 12 and 32 stored as is
        rtcal_pkg::ADDR_DY_HOUR: nxt_regs.dy_hour = rx_byte[5:0];
        default:                 nxt_regs = regs_ff;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      regs_ff <= rtcal_pkg::ALARM_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------
  // Match outputs
  // ----------------------------------------
  logic wk_hit, dy_hit;
  logic wk_match_ff, dy_match_ff;

  rtcal_alarm_match u_match (
    .alarm      (regs_ff),
    .now        (cur_time),
    .weekly_hit (wk_hit),
    .daily_hit  (dy_hit)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wk_match_ff <= 1'b0;
      dy_match_ff <= 1'b0;
    end else begin
      wk_match_ff <= wk_hit;
      dy_match_ff <= dy_hit;
    end
  end

  assign weekly_match      = wk_match_ff;
  assign daily_match       = dy_match_ff;
  assign serial_io_pin_out = sio_out_ff;
  assign serial_io_pin_oe  = sio_oe_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cmd_byte;
    byte_done && phase_ff == rtcal_pkg::RTCAL_CMD;
  endsequence

  sequence s_burst_byte;
    byte_done && phase_ff == rtcal_pkg::RTCAL_DATA && !fmt_ff[rtcal_pkg::FMT_SINGLE_BIT];
  endsequence

  property p_wk_min;
    wr_commit && addr_ff == rtcal_pkg::ADDR_WK_MIN |=> regs_ff.wk_min == $past(rx_byte[6:0]);
  endproperty
  a_wk_min: assert property (p_wk_min) else $error("weekly minute not stored");

  property p_wk_hour;
    wr_commit && addr_ff == rtcal_pkg::ADDR_WK_HOUR |=> regs_ff.wk_hour == $past(rx_byte[5:0]);
  endproperty
  a_wk_hour: assert property (p_wk_hour) else $error("weekly hour not stored");

  property p_wk_days;
    wr_commit && addr_ff == rtcal_pkg::ADDR_WK_DAYS |=> regs_ff.wk_days == $past(rx_byte[6:0]);
  endproperty
  a_wk_days: assert property (p_wk_days) else $error("day mask not stored");

  property p_dy_hour;
    wr_commit && addr_ff == rtcal_pkg::ADDR_DY_HOUR |=> regs_ff.dy_hour == $past(rx_byte[5:0]);
  endproperty
  a_dy_hour: assert property (p_dy_hour) else $error("daily hour not stored");

  property p_pol_latch;
    sel_rise |=> pol_ff == $past(sclk_f) && bit_cnt_ff == rtcal_pkg::BIT_CNT_RST;
  endproperty
  a_pol_latch: assert property (p_pol_latch) else $error("select rise framing wrong");

  property p_cmd_load;
    s_cmd_byte |=> addr_ff == $past(rx_byte[7:4]) && fmt_ff == $past(rx_byte[3:0])
                   && phase_ff == rtcal_pkg::RTCAL_DATA;
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command byte not loaded");

  property p_burst_inc;
    s_burst_byte |=> addr_ff == $past(addr_inc);
  endproperty
  a_burst_inc: assert property (p_burst_inc) else $error("burst address not advanced");

  property p_empty_mask;
    regs_ff.wk_days == 7'h00 |=> !wk_match_ff;
  endproperty
  a_empty_mask: assert property (p_empty_mask) else $error("match with empty mask");

  property p_msb_out;
    drv_edge && phase_ff == rtcal_pkg::RTCAL_DATA && in_read
      |=> serial_io_pin_oe && serial_io_pin_out == $past(tx_ff[7]);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("read bit order wrong");

  property p_oe_frame;
    !sel_f |=> !serial_io_pin_oe;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("driving outside frame");

endmodule

// ===== shared/rtcal_pkg.sv
package rtcal_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [3:0] ADDR_WK_MIN  = 4'h8;
  localparam logic [3:0] ADDR_WK_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WK_DAYS = 4'hA;
  localparam logic [3:0] ADDR_DY_MIN  = 4'hB;
  localparam logic [3:0] ADDR_DY_HOUR = 4'hC;
  localparam logic [3:0] ADDR_LAST    = 4'hF;

  // ----------------------------------------
  // Transfer format codes and fields
  // ----------------------------------------
  localparam logic [3:0] FMT_WR_SINGLE  = 4'h8;
  localparam logic [3:0] FMT_WR_BURST   = 4'h0;
  localparam logic [3:0] FMT_RD_SINGLE  = 4'hC;
  localparam logic [3:0] FMT_RD_BURST   = 4'h4;
  localparam int unsigned FMT_READ_BIT   = 2;
  localparam int unsigned FMT_SINGLE_BIT = 3;
  localparam int unsigned HOUR_PM_BIT    = 5;

  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam logic [2:0] BIT_CNT_RST  = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] DAY_CODE_MAX = 3'h6;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [3:0] NIBBLE_RST   = 4'h0;

  typedef enum logic [1:0] {
    RTCAL_IDLE = 2'b00,
    RTCAL_CMD  = 2'b01,
    RTCAL_DATA = 2'b11
  } rtcal_phase_e;

  typedef struct packed {
    logic [6:0] wk_min;
    logic [5:0] wk_hour;
    logic [6:0] wk_days;
    logic [6:0] dy_min;
    logic [5:0] dy_hour;
  } rtcal_alarm_s;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [2:0] day;
  } rtcal_time_s;

  localparam rtcal_alarm_s ALARM_RST = '0;

endpackage

// ===== core/rtcal_pin_sync.sv
module rtcal_pin_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);

  // ----------------------------------------
  // Three stages; level moves when 2 and 3 agree
  // ----------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_lvl;

    always_comb begin
      nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        s1_ff  <= 1'b0;
        s2_ff  <= 1'b0;
        s3_ff  <= 1'b0;
        lvl_ff <= 1'b0;
      end else begin
        s1_ff  <= async_in[i];
        s2_ff  <= s1_ff;
        s3_ff  <= s2_ff;
        lvl_ff <= nxt_lvl;
      end
    end

    assign level_out[i] = lvl_ff;
  end

endmodule

// ===== core/rtcal_alarm_match.sv
module rtcal_alarm_match (
  input  wire rtcal_pkg::rtcal_alarm_s alarm,
  input  wire rtcal_pkg::rtcal_time_s  now,
  output logic                         weekly_hit,
  output logic                         daily_hit
);

  logic day_sel;
  logic time_wk;
  logic time_dy;

  always_comb begin
    day_sel = (now.day <= rtcal_pkg::DAY_CODE_MAX) ? alarm.wk_days[now.day] : 1'b0;
    // hour bit 5 compared raw
    // Bit 5 is tens or afternoon flag; both modes compare all six bits alike
    time_wk = (now.minute == alarm.wk_min) && (now.hour == alarm.wk_hour);
    time_dy = (now.minute == alarm.dy_min) && (now.hour == alarm.dy_hour);
    weekly_hit = time_wk && day_sel && (alarm.wk_days != 7'h00);
    daily_hit  = time_dy;
  end

endmodule

// ===== verification/rtcal_host_model.sv
module rtcal_host_model (
  input  wire logic clk,
  input  wire logic io_line,
  output logic      select_pin,
  output logic      sclk_pin,
  output logic      host_io,
  output logic      host_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half of the 80 ns period, in 5 ns cycles
  localparam int HALF = 8;

  initial begin
    select_pin = 1'b0;
    sclk_pin = 1'b0;
    host_io = 1'b0;
    host_oe = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(negedge clk);
  endtask

  // ----------------------------------------
  // Framed transfer
  // ----------------------------------------
  // select frames
  task automatic frame(input logic pol, input int nbits, input logic [7:0] tx [16],
                       input logic [15:0] rd_sel, output logic [7:0] rx [16]);
    sclk_pin = pol;
    half_wait();
    select_pin = 1'b1;
    half_wait();
    for (int k = 0; k < nbits; k++) begin
      host_oe = !rd_sel[k/8];
      // Released line toggles so no stale level can pass for data
      host_io = rd_sel[k/8] ? ~host_io : tx[k/8][7-k%8];
      sclk_pin = !pol;
      half_wait();
      rx[k/8][7-k%8] = io_line;
      sclk_pin = pol;
      half_wait();
    end
    host_oe = 1'b0;
    select_pin = 1'b0;
    half_wait();
  endtask
endmodule

// ===== verification/tb_rtcal_serial_port.sv
module tb_rtcal_serial_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  select_pin;
  logic                  sclk_pin;
  logic                  host_io;
  logic                  host_oe;
  logic                  dut_out;
  logic                  dut_oe;
  logic                  wk_hit;
  logic                  dy_hit;
  rtcal_pkg::rtcal_time_s now = '0;
  rtcal_pkg::rtcal_time_s t;
  wire                   io_line = dut_oe ? dut_out : (host_oe ? host_io : ~host_io);
  int                    n_fail = 0;
  int                    n_checks = 0;
  logic [31:0]           rng = 32'h0000B595;
  logic [31:0]           r;
  logic [3:0]            a;
  logic [1:0]            eh;
  logic [7:0]            regs [16] = '{default: 8'h00};
  logic [7:0]            tx [16];
  logic [7:0]            rx [16];

  always #2.5 clk = ~clk;

  rtcal_host_model host (
    .clk        (clk),
    .io_line    (io_line),
    .select_pin (select_pin),
    .sclk_pin   (sclk_pin),
    .host_io    (host_io),
    .host_oe    (host_oe)
  );

  rtcal_serial_port DUT (
    .clk               (clk),
    .rstn              (rstn),
    .select_pin        (select_pin),
    .sclk_pin          (sclk_pin),
    .serial_io_pin_in  (io_line),
    .serial_io_pin_out (dut_out),
    .serial_io_pin_oe  (dut_oe),
    .cur_time          (now),
    .weekly_match      (wk_hit),
    .daily_match       (dy_hit)
  );

  // ----------------------------------------
  // Line ownership
  // ----------------------------------------
  // no drive while host drives
  always @(negedge clk) begin
    if (host_oe) begin
      check_bit(dut_oe, 1'b0);
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [7:0] mask_of(input logic [3:0] adr);
    if (adr == rtcal_pkg::ADDR_WK_HOUR || adr == rtcal_pkg::ADDR_DY_HOUR) return 8'h3F;
    if (adr >= rtcal_pkg::ADDR_WK_MIN && adr <= rtcal_pkg::ADDR_DY_HOUR) return 8'h7F;
    return 8'h00;
  endfunction

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic logic [7:0] rand_hour();
    logic [31:0] q;
    q = rnd();
    if (q[0]) return bcd(int'(q[15:8] % 24));
    return bcd(int'(q[15:8] % 12) + 1) | (q[1] ? 8'h20 : 8'h00);
  endfunction

  function automatic logic [1:0] exp_hits(input rtcal_pkg::rtcal_time_s tm);
    logic w;
    logic d;
    w = tm.minute == regs[8][6:0] && tm.hour == regs[9][5:0];
    w = w && tm.day <= rtcal_pkg::DAY_CODE_MAX && regs[10][tm.day];
    d = tm.minute == regs[11][6:0] && tm.hour == regs[12][5:0];
    return {w, d};
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr1(input logic pol, input logic [3:0] adr, input logic [7:0] d);
    tx[0] = {adr, rtcal_pkg::FMT_WR_SINGLE};
    tx[1] = d;
    host.frame(pol, 16, tx, 16'h0000, rx);
    if (mask_of(adr) != 8'h00) regs[adr] = d & mask_of(adr);
  endtask

  task automatic rd1_check(input logic pol, input logic [3:0] adr);
    tx[0] = {adr, rtcal_pkg::FMT_RD_SINGLE};
    host.frame(pol, 16, tx, 16'h0002, rx);
    check_byte(rx[1], regs[adr]);
    check_bit(dut_oe, 1'b0);
  endtask

  task automatic rdb_check(input logic pol, input logic [3:0] adr, input int n);
    tx[0] = {adr, rtcal_pkg::FMT_RD_BURST};
    host.frame(pol, 8 * (n + 1), tx, 16'hFFFE, rx);
    for (int i = 1; i <= n; i++) begin
      check_byte(rx[i], regs[4'(adr + i - 1)]);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rdb_check(1'b0, rtcal_pkg::ADDR_WK_MIN, 5);
    for (int k = 0; k < 20; k++) begin
      r = rnd();
      a = (k < 5) ? 4'(8 + k) : r[11:8];
      wr1(r[0], a, r[23:16]);
      rd1_check(r[1], a);
    end
    tx[0] = {4'hB, rtcal_pkg::FMT_WR_BURST};
    for (int i = 1; i < 8; i++) begin
      tx[i] = 8'(rnd());
      if (mask_of(4'(10 + i)) != 8'h00) regs[10 + i] = tx[i] & mask_of(4'(10 + i));
    end
    host.frame(1'b1, 64, tx, 16'h0000, rx);
    rdb_check(1'b0, 4'hC, 14);
    // Write then read in one frame
    tx[0] = {rtcal_pkg::ADDR_WK_HOUR, rtcal_pkg::FMT_WR_SINGLE};
    tx[1] = 8'hE5;
    tx[2] = {rtcal_pkg::ADDR_WK_HOUR, rtcal_pkg::FMT_RD_SINGLE};
    host.frame(1'b1, 32, tx, 16'h0008, rx);
    regs[9] = 8'h25;
    check_byte(rx[3], 8'h25);
    // Partial data byte is dropped, next frame starts clean
    tx[0] = {rtcal_pkg::ADDR_WK_MIN, rtcal_pkg::FMT_WR_SINGLE};
    tx[1] = 8'hFF;
    host.frame(1'b0, 12, tx, 16'h0000, rx);
    rd1_check(1'b1, rtcal_pkg::ADDR_WK_MIN);
    for (int rnd_i = 0; rnd_i < 2; rnd_i++) begin
      wr1(1'b0, rtcal_pkg::ADDR_WK_MIN, bcd(int'(rnd() % 60)));
      wr1(1'b1, rtcal_pkg::ADDR_WK_HOUR, rand_hour());
      wr1(1'b0, rtcal_pkg::ADDR_WK_DAYS, rnd_i == 0 ? 8'(rnd()) : 8'h00);
      wr1(1'b1, rtcal_pkg::ADDR_DY_MIN, bcd(int'(rnd() % 60)));
      wr1(1'b0, rtcal_pkg::ADDR_DY_HOUR, rand_hour());
      for (int k = 0; k < 60; k++) begin
        r = rnd();
        t.minute = r[0] ? regs[8][6:0] : (r[1] ? regs[11][6:0] : 7'(bcd(int'(r[31:20] % 60))));
        t.hour = r[2] ? regs[9][5:0] : (r[3] ? regs[12][5:0] : 6'(rand_hour()));
        t.day = r[6:4];
        now = t;
        @(negedge clk);
        eh = exp_hits(t);
        check_bit(wk_hit, eh[1]);
        check_bit(dy_hit, eh[0]);
      end
    end
    report_and_stop();
  end

  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
endmodule
